/* File: odbg_core.sv */
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module odbg_core #(
   parameter int RST_CYCLES = odbg_pkg::RST_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_clk_en,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // CPU side
   input wire logic i_decode_valid,
   input wire logic [7:0] i_decode_opcode,
   input wire logic i_cpu_halted,
   input wire logic i_flash_read_protect_option,
   input wire logic [7:0] i_host_rd_byte,
   output logic o_fetch_stop,
   output logic o_brk_as_nop,
   output logic o_sys_reset,
   output logic [7:0] o_host_rd_byte,
   output logic o_ack_valid,
   output logic [7:0] o_ack_byte,
   output logic o_irq
);
   // ======================================================
   // Reset release and pin synchronisers
   // ======================================================
   logic rst_meta_ff; // First reset flop
   logic rst_n_ff; // Released reset used everywhere
   // Assert async, release through two flops
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end

   logic read_protect_s; // Synchronised read-protect option
   logic halt_s; // Synchronised halt state
   odbg_sync #(.W(2)) u_sync (
      .i_clk(i_core_clk),
      .i_rst_n(rst_n_ff),
      .i_en(i_clk_en),
      .i_d({i_flash_read_protect_option, i_cpu_halted}),
      .o_q({read_protect_s, halt_s})
   );

   // ======================================================
   // Bus address phase capture
   // ======================================================
   logic wr_pend_ff; // Write data phase pending
   logic [7:0] addr_ff; // Captured offset
   logic rd_ok; // Read data available this phase
   logic access; // Valid address phase
   assign access = i_hsel && i_hready && i_htrans[1];
   // Latch the address phase; zero-wait slave
   always_ff @(posedge i_core_clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         wr_pend_ff <= 1'b0;
         addr_ff <= 8'h00;
      end
      else if (i_clk_en)
      begin
         wr_pend_ff <= access && i_hwrite;
         if (access)
            addr_ff <= i_haddr[7:0];
      end
   end
   assign rd_ok = 1'b1;

   // Write strobes decoded from the data phase
   function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off);
      wr_hit = (a == off);
   endfunction
   logic wr_ctrl; // Control register written
   logic wr_irqs; // Status write-one-to-clear
   logic wr_mask; // Mask written
   assign wr_ctrl = wr_pend_ff && wr_hit(addr_ff, odbg_pkg::ADDR_CTRL);
   assign wr_irqs = wr_pend_ff && wr_hit(addr_ff, odbg_pkg::ADDR_IRQ_STAT);
   assign wr_mask = wr_pend_ff && wr_hit(addr_ff, odbg_pkg::ADDR_IRQ_MASK);

   // ======================================================
   // Breakpoint detect and reset timer
   // ======================================================
   odbg_pkg::odbg_ctrl_type ctrl_ff; // Live control bits
   odbg_pkg::odbg_decode_type dec; // Decode carrier
   logic brk_hit; // Breakpoint taken this cycle
   logic rst_busy; // Requested reset running
   logic rst_done; // Requested reset finished
   assign dec = '{valid: i_decode_valid, opcode: i_decode_opcode};
   // Only honoured while running, so a halted core cannot re-trigger
   assign brk_hit = dec.valid && (dec.opcode == odbg_pkg::BREAK_OPCODE)
                    && ctrl_ff.brk_en && !ctrl_ff.dbg_mode;

   odbg_rst_timer #(.CYCLES(RST_CYCLES)) u_rtim (
      .i_clk(i_core_clk),
      .i_rst_n(rst_n_ff),
      .i_en(i_clk_en),
      .i_start(ctrl_ff.rst_req),
      .o_busy(rst_busy),
      .o_done(rst_done)
   );

   // ======================================================
   // Control register
   // ======================================================
   logic [7:0] wd; // Write data low byte
   assign wd = i_hwdata[7:0];
   // Debugger state lives on the core reset only, so the self-requested
   // system reset never disturbs it
   always_ff @(posedge i_core_clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         ctrl_ff <= '0;
      else if (i_clk_en)
      begin
         // Debug bit: breakpoint set beats any software clear
         if (brk_hit)
            ctrl_ff.dbg_mode <= 1'b1;
         else if (wr_ctrl)
         begin
            if (wd[odbg_pkg::CTL_DEBUG_MODE])
               ctrl_ff.dbg_mode <= 1'b1;
            else if (read_protect_s)
               ctrl_ff.dbg_mode <= ctrl_ff.dbg_mode;
            else
               ctrl_ff.dbg_mode <= 1'b0;
         end
         if (wr_ctrl)
         begin
            ctrl_ff.brk_en <= wd[odbg_pkg::CTL_BREAK_EN];
            ctrl_ff.ack_en <= wd[odbg_pkg::CTL_ACKEN];
         end
         // Reset bit: completion wins, a new write then rearms it
         if (rst_done)
            ctrl_ff.rst_req <= 1'b0;
         else if (wr_ctrl && wd[odbg_pkg::CTL_RST])
            ctrl_ff.rst_req <= 1'b1;
      end
   end

   // ======================================================
   // CPU-facing outputs
   // ======================================================
   // Registered copies (brk_as_nop inverted), one cycle behind the control bits and the reset timer busy flag
   always_ff @(posedge i_core_clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         o_fetch_stop <= 1'b0;
         o_brk_as_nop <= 1'b1;
         o_sys_reset <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_fetch_stop <= ctrl_ff.dbg_mode;
         o_brk_as_nop <= !ctrl_ff.brk_en;
         o_sys_reset <= rst_busy;
      end
   end

   // Host register-read gate: blocked reads give FFH
   always_ff @(posedge i_core_clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         o_host_rd_byte <= odbg_pkg::BLOCKED_BYTE;
      else if (i_clk_en)
      begin
         if (!ctrl_ff.dbg_mode || read_protect_s)
            o_host_rd_byte <= odbg_pkg::BLOCKED_BYTE;
         else
            o_host_rd_byte <= i_host_rd_byte;
      end
   end

   // Acknowledge character: one-cycle strobe to the link
   always_ff @(posedge i_core_clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         o_ack_valid <= 1'b0;
         o_ack_byte <= 8'h00;
      end
      else if (i_clk_en)
      begin
         o_ack_valid <= brk_hit && ctrl_ff.ack_en;
         if (brk_hit && ctrl_ff.ack_en)
            o_ack_byte <= odbg_pkg::ACK_CHAR;
      end
   end

   // ======================================================
   // Status word and interrupts
   // ======================================================
   logic [7:0] stat; // debug_status value
   always_comb
   begin
      stat = 8'h00;
      stat[odbg_pkg::ST_DEBUG] = ctrl_ff.dbg_mode;
      stat[odbg_pkg::ST_HALT] = halt_s;
      stat[odbg_pkg::ST_RDP] = !read_protect_s;
   end

   logic [odbg_pkg::EV_W-1:0] ev; // Event pulses
   logic [odbg_pkg::EV_W-1:0] irq_st_ff; // Sticky flags
   logic [odbg_pkg::EV_W-1:0] irq_mask_ff; // Enables
   always_comb
   begin
      ev = '0;
      ev[odbg_pkg::EV_BREAK] = brk_hit;
      ev[odbg_pkg::EV_RESET_DONE] = rst_done;
      ev[odbg_pkg::EV_ACK_SENT] = brk_hit && ctrl_ff.ack_en;
   end
   // Set wins over a same-cycle clear so no event is lost
   always_ff @(posedge i_core_clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         irq_st_ff <= '0;
         irq_mask_ff <= '0;
      end
      else if (i_clk_en)
      begin
         irq_st_ff <= (irq_st_ff & ~(wr_irqs ? i_hwdata[odbg_pkg::EV_W-1:0] : '0)) | ev;
         if (wr_mask)
            irq_mask_ff <= i_hwdata[odbg_pkg::EV_W-1:0];
      end
   end
   // Level interrupt, registered
   always_ff @(posedge i_core_clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         o_irq <= 1'b0;
      else if (i_clk_en)
         o_irq <= |(((irq_st_ff & ~(wr_irqs ? i_hwdata[odbg_pkg::EV_W-1:0] : '0)) | ev)
                    & (wr_mask ? i_hwdata[odbg_pkg::EV_W-1:0] : irq_mask_ff));
   end

   // ======================================================
   // Read data, registered in the address phase
   // ======================================================
   logic [7:0] ctrl_rd; // Control register read image
   assign ctrl_rd = {ctrl_ff.dbg_mode, ctrl_ff.brk_en, ctrl_ff.ack_en, 4'h0, ctrl_ff.rst_req};
   // Unmapped offsets read zero with OKAY
   always_ff @(posedge i_core_clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         o_hrdata <= 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_hreadyout <= rd_ok;
         o_hresp <= 1'b0;
         if (access && !i_hwrite)
         begin
            case (i_haddr[7:0])
               odbg_pkg::ADDR_CTRL: o_hrdata <= {24'h00_0000, ctrl_rd};
               odbg_pkg::ADDR_STAT: o_hrdata <= {24'h00_0000, stat};
               odbg_pkg::ADDR_IRQ_STAT: o_hrdata <= {29'h0000_0000, irq_st_ff};
               odbg_pkg::ADDR_IRQ_MASK: o_hrdata <= {29'h0000_0000, irq_mask_ff};
               odbg_pkg::ADDR_HOST_RD: o_hrdata <= {24'h00_0000, o_host_rd_byte};
               odbg_pkg::ADDR_ACK: o_hrdata <= {24'h00_0000, o_ack_byte};
               default: o_hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ======================================================
   // Checks
   // ======================================================
   // Taken breakpoint, then the debug bit one edge later; software may
   // clear it again right after, so only the first step is checked here
   sequence s_break;
      i_clk_en && brk_hit;
   endsequence
   sequence s_debug_set;
      ctrl_ff.dbg_mode;
   endsequence
   AST_BREAK_STOPS: assert property (@(posedge i_core_clk) disable iff (!rst_n_ff)
      s_break |=> s_debug_set)
      else $error("breakpoint did not stop the core");
   AST_FETCH_FOLLOWS: assert property (@(posedge i_core_clk) disable iff (!rst_n_ff)
      i_clk_en |=> o_fetch_stop == $past(ctrl_ff.dbg_mode))
      else $error("fetch stop does not follow debug bit");
   AST_RESUME: assert property (@(posedge i_core_clk) disable iff (!rst_n_ff)
      (i_clk_en && wr_ctrl && !wd[odbg_pkg::CTL_DEBUG_MODE] && !read_protect_s && !brk_hit)
      |=> !ctrl_ff.dbg_mode)
      else $error("debug bit not cleared");
   AST_PROTECT_HOLD: assert property (@(posedge i_core_clk) disable iff (!rst_n_ff)
      (i_clk_en && read_protect_s && ctrl_ff.dbg_mode) |=> ctrl_ff.dbg_mode)
      else $error("protected debug bit was cleared");
   // With breakpoints off only software may raise the debug bit
   AST_NOP: assert property (@(posedge i_core_clk) disable iff (!rst_n_ff)
      (i_clk_en && !ctrl_ff.brk_en && !wr_ctrl && !ctrl_ff.dbg_mode) |=> !ctrl_ff.dbg_mode)
      else $error("breakpoint taken while disabled");
   AST_ACK: assert property (@(posedge i_core_clk) disable iff (!rst_n_ff)
      (i_clk_en && brk_hit && ctrl_ff.ack_en) |=> o_ack_valid && o_ack_byte == odbg_pkg::ACK_CHAR)
      else $error("acknowledge not sent");
   AST_RST_CLR: assert property (@(posedge i_core_clk) disable iff (!rst_n_ff)
      (i_clk_en && rst_done) |=> !ctrl_ff.rst_req)
      else $error("reset bit not cleared");
   AST_STATUS: assert property (@(posedge i_core_clk) disable iff (!rst_n_ff)
      stat[odbg_pkg::ST_DEBUG] == ctrl_ff.dbg_mode && stat[4:0] == 5'h00
      && stat[odbg_pkg::ST_RDP] == !read_protect_s)
      else $error("status image wrong");
   AST_BLOCK: assert property (@(posedge i_core_clk) disable iff (!rst_n_ff)
      (i_clk_en && (!ctrl_ff.dbg_mode || read_protect_s))
      |=> o_host_rd_byte == odbg_pkg::BLOCKED_BYTE)
      else $error("blocked read leaked data");
endmodule // odbg_core
`default_nettype wire

/* File: odbg_pkg.sv */
package odbg_pkg;
   // ======================================================
   // Register map (byte addresses on the AHB-Lite slave)
   // ======================================================
   localparam logic [7:0] ADDR_CTRL = 8'h00; // debug_control
   localparam logic [7:0] ADDR_STAT = 8'h04; // debug_status
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08; // Sticky event flags
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C; // Interrupt mask
   localparam logic [7:0] ADDR_HOST_RD = 8'h10; // Host register-read data gate
   localparam logic [7:0] ADDR_ACK = 8'h14; // Last acknowledge byte sent
   // ======================================================
   // Field positions
   // ======================================================
   localparam int CTL_DEBUG_MODE = 7;
   localparam int CTL_BREAK_EN = 6;
   localparam int CTL_ACKEN = 5;
   localparam int CTL_RST = 0;
   localparam int ST_DEBUG = 7;
   localparam int ST_HALT = 6;
   localparam int ST_RDP = 5;
   localparam int EV_BREAK = 0; // Breakpoint taken
   localparam int EV_RESET_DONE = 1; // Requested reset finished
   localparam int EV_ACK_SENT = 2; // Acknowledge byte handed to link
   localparam int EV_W = 3;
   // ======================================================
   // Values and timing
   // ======================================================
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_WMASK = 8'hE1; // Writable control bits
   localparam logic [7:0] BREAK_OPCODE = 8'h00;
   localparam logic [7:0] ACK_CHAR = 8'hFF;
   localparam logic [7:0] BLOCKED_BYTE = 8'hFF;
   localparam int RST_TIME_US = 16; // Length of the requested reset
   localparam int CLK_MHZ = 100;
   localparam int RST_CYCLES = RST_TIME_US * CLK_MHZ;
   // ======================================================
   // Carriers
   // ======================================================
   typedef struct packed
   {
      logic dbg_mode;
      logic brk_en;
      logic ack_en;
      logic rst_req;
   } odbg_ctrl_type;
   typedef struct packed
   {
      logic valid;
      logic [7:0] opcode;
   } odbg_decode_type;
endpackage

/* File: odbg_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// Two-flop synchroniser for pin inputs
// ======================================================
module odbg_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_en,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_ff; // First stage, read only by o_q
   // Sampling chain, frozen with the clock enable
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta_ff <= '0;
         o_q <= '0;
      end
      else if (i_en)
      begin
         meta_ff <= i_d;
         o_q <= meta_ff;
      end
   end
endmodule // odbg_sync
`default_nettype wire

/* File: odbg_rst_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// Counts out the requested reset sequence
// ======================================================
module odbg_rst_timer #(
   parameter int CYCLES = odbg_pkg::RST_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_en,
   input wire logic i_start,
   output logic o_busy,
   output logic o_done
);
   logic [31:0] cnt_ff; // Cycles left
   // Load on start, count down, pulse done at the end
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_ff <= 32'h0000_0000;
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end
      else if (i_en)
      begin
         o_done <= 1'b0;
         // Not in the done cycle: the request bit is still high then and
         // would otherwise rearm a second, unrequested reset sequence
         if (i_start && !o_busy && !o_done)
         begin
            cnt_ff <= 32'(CYCLES - 1);
            o_busy <= 1'b1;
         end
         else if (o_busy)
         begin
            if (cnt_ff == 32'h0000_0000)
            begin
               o_busy <= 1'b0;
               o_done <= 1'b1;
            end
            else
               cnt_ff <= cnt_ff - 32'h0000_0001;
         end
      end
   end
endmodule // odbg_rst_timer
`default_nettype wire

/* File: odbg_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// CPU model: fetches and decodes one opcode per cycle
// ======================================================
module odbg_cpu_model (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_run,
   input wire logic [7:0] i_opcode,
   input wire logic i_fetch_stop,
   output logic o_decode_valid,
   output logic [7:0] o_decode_opcode,
   output logic [15:0] o_fetch_count
);
   // Decode only while fetch runs; idle opcode toggles, so a stale value comes back every second idle cycle
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_decode_valid <= 1'b0;
         o_decode_opcode <= 8'h55;
         o_fetch_count <= 16'h0000;
      end
      else if (i_run && !i_fetch_stop)
      begin
         o_decode_valid <= 1'b1;
         o_decode_opcode <= i_opcode;
         o_fetch_count <= o_fetch_count + 16'h0001;
      end
      else
      begin
         o_decode_valid <= 1'b0;
         o_decode_opcode <= ~o_decode_opcode;
      end
   end
endmodule // odbg_cpu_model
`default_nettype wire

/* File: onchip_debug_control_status_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module onchip_debug_control_status_tb;
   // ======================================================
   // Signals
   // ======================================================
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic hsel = 1'b0; // Bus request, held until accepted
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   logic run = 1'b0; // CPU model fetch enable
   logic [7:0] opcode = 8'h11;
   logic halted = 1'b0;
   logic read_prot = 1'b0;
   logic [7:0] host_byte = 8'h5A;
   logic dec_valid, fetch_stop, brk_nop, sys_rst, ack_valid, irq;
   logic [7:0] dec_op, host_out, ack_byte;
   logic [15:0] fetch_cnt, cnt_old;
   logic [31:0] q;
   int errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   // ======================================================
   // Clock, design and partner
   // ======================================================
   initial
   begin
      forever #5 core_clk = ~core_clk;
   end
   // Short reset sequence keeps the run brief
   odbg_core #(.RST_CYCLES(8)) dut (.i_core_clk(core_clk), .i_reset_n(reset_n),
      .i_clk_en(1'b1), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready),
      .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
      .i_decode_valid(dec_valid), .i_decode_opcode(dec_op), .i_cpu_halted(halted),
      .i_flash_read_protect_option(read_prot), .i_host_rd_byte(host_byte),
      .o_fetch_stop(fetch_stop),
      .o_brk_as_nop(brk_nop), .o_sys_reset(sys_rst), .o_host_rd_byte(host_out),
      .o_ack_valid(ack_valid), .o_ack_byte(ack_byte), .o_irq(irq));
   odbg_cpu_model cpu (.i_clk(core_clk), .i_rst_n(reset_n), .i_run(run),
      .i_opcode(opcode), .i_fetch_stop(fetch_stop), .o_decode_valid(dec_valid),
      .o_decode_opcode(dec_op), .o_fetch_count(fetch_cnt));
   // ======================================================
   // Tasks
   // ======================================================
   task automatic complete_run();
      $display("comparisons %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One single transfer; the wait on hready has no fixed length
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge core_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      if (wr)
         hwdata <= d;
      do @(posedge core_clk); while (hready !== 1'b1);
      q = hrdata; // Read data taken at the closing edge
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      xfer(1'b0, a, 32'h0000_0000);
      chk(nm, e, q);
   endtask
   function automatic logic pick(input int sel);
      case (sel)
         0: return fetch_stop;
         1: return ack_valid;
         2: return sys_rst;
         default: return irq;
      endcase
   endfunction
   // Bounded wait for an output level, one look per edge
   task automatic wait_for(input int sel, input logic v, input int lim, input string nm);
      int n;
      logic s;
      n = 0;
      s = ~v;
      while (s !== v && n < lim)
      begin
         @(posedge core_clk);
         s = pick(sel);
         n++;
      end
      chk(nm, {31'h0, v}, {31'h0, s});
   endtask
   // Hang guard: ceiling far above the hundred-odd cycles the tests need
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         errors++;
         complete_run();
      end
   end
   // ======================================================
   // Tests
   // ======================================================
   initial
   begin
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(odbg_pkg::ADDR_CTRL, 32'h0000_0000, "ctrl_reset");
      rd(odbg_pkg::ADDR_STAT, 32'h0000_0020, "stat_reset");
      rd(8'h20, 32'h0000_0000, "unmapped");
      chk("brk_as_nop", 32'h1, {31'h0, brk_nop});
      // Opcode 00H with breakpoints off passes as a no-op
      opcode <= 8'h00;
      run <= 1'b1;
      repeat (10) @(posedge core_clk);
      rd(odbg_pkg::ADDR_CTRL, 32'h0000_0000, "ctrl_no_brk");
      chk("stop_no_brk", 32'h0, {31'h0, fetch_stop});
      opcode <= 8'h11;
      wr(odbg_pkg::ADDR_CTRL, 32'h0000_0060);
      rd(odbg_pkg::ADDR_CTRL, 32'h0000_0060, "ctrl_arm");
      chk("brk_armed", 32'h0, {31'h0, brk_nop});
      // Breakpoint: acknowledge byte, then fetch halts
      opcode <= 8'h00;
      wait_for(1, 1'b1, 10, "ack_pulse");
      chk("ack_byte", 32'h0000_00FF, {24'h0, ack_byte});
      wait_for(0, 1'b1, 5, "fetch_stop");
      cnt_old = fetch_cnt;
      repeat (10) @(posedge core_clk);
      chk("fetch_frozen", {16'h0, cnt_old}, {16'h0, fetch_cnt});
      rd(odbg_pkg::ADDR_CTRL, 32'h0000_00E0, "ctrl_brk");
      rd(odbg_pkg::ADDR_STAT, 32'h0000_00A0, "stat_dbg");
      rd(odbg_pkg::ADDR_ACK, 32'h0000_00FF, "ack_reg");
      rd(odbg_pkg::ADDR_HOST_RD, 32'h0000_005A, "host_open");
      // Interrupt raised, masked, unmasked and cleared
      // A mask bit of one lets its flag through to the interrupt line
      rd(odbg_pkg::ADDR_IRQ_STAT, 32'h0000_0005, "irq_flags");
      wait_for(3, 1'b0, 5, "irq_reset_mask");
      wr(odbg_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
      wait_for(3, 1'b1, 5, "irq_up");
      wr(odbg_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
      wait_for(3, 1'b0, 5, "irq_masked");
      wr(odbg_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
      wait_for(3, 1'b1, 5, "irq_unmasked");
      wr(odbg_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
      wait_for(3, 1'b0, 5, "irq_cleared");
      rd(odbg_pkg::ADDR_IRQ_STAT, 32'h0000_0000, "irq_w1c");
      // Resume with a harmless opcode so no new breakpoint fires
      opcode <= 8'h11;
      wr(odbg_pkg::ADDR_CTRL, 32'h0000_0060);
      wait_for(0, 1'b0, 5, "fetch_resume");
      cnt_old = fetch_cnt;
      repeat (5) @(posedge core_clk);
      chk("fetch_moves", 32'h1, {31'h0, fetch_cnt != cnt_old});
      rd(odbg_pkg::ADDR_HOST_RD, 32'h0000_00FF, "host_normal");
      // Read protection active
      read_prot <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(odbg_pkg::ADDR_STAT, 32'h0000_0000, "stat_prot");
      wr(odbg_pkg::ADDR_CTRL, 32'h0000_0080);
      wr(odbg_pkg::ADDR_CTRL, 32'h0000_0000);
      rd(odbg_pkg::ADDR_CTRL, 32'h0000_0080, "ctrl_locked");
      rd(odbg_pkg::ADDR_HOST_RD, 32'h0000_00FF, "host_prot");
      halted <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(odbg_pkg::ADDR_STAT, 32'h0000_00C0, "stat_halt");
      halted <= 1'b0;
      read_prot <= 1'b0;
      repeat (4) @(posedge core_clk);
      // Requested reset keeps the debugger state
      wr(odbg_pkg::ADDR_CTRL, 32'h0000_0081);
      wait_for(2, 1'b1, 5, "sys_reset_on");
      wait_for(2, 1'b0, 20, "sys_reset_off");
      repeat (2) @(posedge core_clk);
      chk("sys_reset_once", 32'h0, {31'h0, sys_rst});
      rd(odbg_pkg::ADDR_CTRL, 32'h0000_0080, "ctrl_after_rst");
      rd(odbg_pkg::ADDR_IRQ_STAT, 32'h0000_0002, "irq_rst_done");
      complete_run();
   end
endmodule // onchip_debug_control_status_tb
`default_nettype wire
